// ### flut_regs.svh
// Purpose: Offsets, reset values and field positions of table entries 5/6
// Assumes: APB byte addresses, printed offsets not all multiples of four
// Notes:   Byte address is four times the register index
`ifndef FLUT_REGS_SVH
`define FLUT_REGS_SVH
`define FLUT_IDX_LIMIT5   8'h58
`define FLUT_IDX_DUTY5    8'h59
`define FLUT_IDX_LIMIT6   8'h5a
`define FLUT_IDX_DUTY6    8'h5b
`define FLUT_IDX_CTRL     8'h4a
`define FLUT_IDX_STATUS   8'h61
`define FLUT_IDX_OFFSET   8'h4e
`define FLUT_IDX_TEMP     8'h63
`define FLUT_RST_LIMIT    8'h7f
`define FLUT_RST_DUTY     8'h3f
`define FLUT_RST_CTRL     8'h00
`define FLUT_RST_OFFSET   8'h00
`define FLUT_CTRL_TEMP_HI 0
`define FLUT_CTRL_DUTY_HI 1
`define FLUT_CTRL_F22K5   2
`define FLUT_CTRL_UNLOCK  5
`endif

// ### flut_pkg.sv
// Purpose: Types shared by the fan speed table entries block
// Assumes: Limits and duty values are 8 bits
// Notes:   Offsets and resets live in flut_regs.svh
package flut_pkg;
	typedef logic [7:0] flut_byte_t;
	typedef logic [9:0] flut_temp_t;
	typedef enum logic [1:0] {
		FLUT_SEL_NONE = 2'b00,
		FLUT_SEL_E5   = 2'b01,
		FLUT_SEL_E6   = 2'b10
	} flut_sel_t;
endpackage : flut_pkg

// ### flut_cmp.sv
// Purpose: Compare one table limit against the remote reading
// Assumes: Reading is 9 bits in half degrees, sign bit dropped upstream
// Notes:   Limit bit 7 is the half-degree bit in high resolution
`timescale 1ns/1ps
module flut_cmp
	import flut_pkg::*;
(
	input  wire logic       temp_hi,
	input  wire flut_byte_t limit,
	input  wire flut_byte_t offset,
	input  wire logic [8:0] reading,
	output logic            exceeds
);
	flut_temp_t lim_half;
	flut_temp_t rd;

	// Limit in half degrees plus table offset (whole degrees)
	always_comb begin
		if (temp_hi) begin
			lim_half = {2'b00, limit[6:0], limit[7]};
			rd = {1'b0, reading};
		end else begin
			lim_half = {2'b00, limit[6:0], 1'b0};
			rd = {1'b0, reading[8:1], 1'b0};
		end
		lim_half = lim_half + {1'b0, offset, 1'b0};
		exceeds = rd > lim_half;
	end
endmodule : flut_cmp

// ### flut_entries.sv
// Purpose: Fan speed table entries 5 and 6 behind an APB slave
// Assumes: Reading arrives as 9 bits, half degrees, sign removed
// Notes:   Zero wait states; unmapped reads return zero, no error
`timescale 1ns/1ps
`include "flut_regs.svh"
module flut_entries
	import flut_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [8:0]  remote_temp,
	output logic             pwm_valid,
	output logic [7:0]       pwm_duty,
	output logic [1:0]       active_entry
);
	flut_byte_t limit5_q;
	flut_byte_t duty5_q;
	flut_byte_t limit6_q;
	flut_byte_t duty6_q;
	flut_byte_t ctrl_q;
	flut_byte_t offset_q;
	logic [8:0] temp_q;
	logic       exc5;
	logic       exc6;
	logic       wr_en;
	logic       rd_en;
	logic [9:0] idx;
	logic       temp_hi;
	logic       duty_hi;
	flut_byte_t rd_d;
	flut_byte_t duty_d;
	flut_sel_t  sel_d;

	// Register index from byte address
	function automatic logic [9:0] reg_index(input logic [11:0] a);
		reg_index = a[11:2];
	endfunction : reg_index

	// Duty byte masking by mode
	function automatic flut_byte_t duty_view(input flut_byte_t d,
		input logic hi);
		duty_view = hi ? d : {2'b00, d[5:0]};
	endfunction : duty_view

	// Limit byte masking by mode
	function automatic flut_byte_t limit_view(input flut_byte_t l,
		input logic hi);
		limit_view = hi ? l : {1'b0, l[6:0]};
	endfunction : limit_view

	assign idx = reg_index(paddr);
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite;
	assign temp_hi = ctrl_q[`FLUT_CTRL_TEMP_HI];
	// Extended duty only when 22.5 kHz selected
	assign duty_hi = ctrl_q[`FLUT_CTRL_DUTY_HI]
		& ctrl_q[`FLUT_CTRL_F22K5];

	// Reading comes from another domain: two-stage sync before use.
	// A third stage passes a word only once two samples agree, so a
	// reading caught mid-change never reaches the comparators.
	logic [8:0] temp_s1_q;
	logic [8:0] temp_s2_q;
	logic [8:0] temp_s3_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			temp_s1_q <= 9'h000;
			temp_s2_q <= 9'h000;
			temp_s3_q <= 9'h000;
			temp_q <= 9'h000;
		end else begin
			temp_s1_q <= remote_temp;
			temp_s2_q <= temp_s1_q;
			temp_s3_q <= temp_s2_q;
			if (temp_s2_q == temp_s3_q)
				temp_q <= temp_s2_q;
		end
	end

	// Control and offset: always writable, control holds the unlock bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `FLUT_RST_CTRL;
			offset_q <= `FLUT_RST_OFFSET;
		end else if (wr_en) begin
			if (idx == 10'(`FLUT_IDX_CTRL))
				ctrl_q <= pwdata[7:0];
			if (idx == 10'(`FLUT_IDX_OFFSET))
				offset_q <= pwdata[7:0];
		end
	end

	// Table entries: writes ignored while locked
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			limit5_q <= `FLUT_RST_LIMIT;
			duty5_q <= `FLUT_RST_DUTY;
			limit6_q <= `FLUT_RST_LIMIT;
			duty6_q <= `FLUT_RST_DUTY;
		end else if (wr_en && ctrl_q[`FLUT_CTRL_UNLOCK]) begin
			unique case (idx)
				10'(`FLUT_IDX_LIMIT5): limit5_q <= pwdata[7:0];
				10'(`FLUT_IDX_DUTY5): duty5_q <= pwdata[7:0];
				10'(`FLUT_IDX_LIMIT6): limit6_q <= pwdata[7:0];
				10'(`FLUT_IDX_DUTY6): duty6_q <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// Limit comparators; offset shared by both entries
	flut_cmp u_cmp5 (
		.temp_hi (temp_hi),
		.limit   (limit5_q),
		.offset  (offset_q),
		.reading (temp_q),
		.exceeds (exc5)
	);
	flut_cmp u_cmp6 (
		.temp_hi (temp_hi),
		.limit   (limit6_q),
		.offset  (offset_q),
		.reading (temp_q),
		.exceeds (exc6)
	);

	// Higher entry wins when both limits are passed
	always_comb begin
		if (exc6) begin
			duty_d = duty_view(duty6_q, duty_hi);
			sel_d = FLUT_SEL_E6;
		end else if (exc5) begin
			duty_d = duty_view(duty5_q, duty_hi);
			sel_d = FLUT_SEL_E5;
		end else begin
			duty_d = 8'h00;
			sel_d = FLUT_SEL_NONE;
		end
	end

	// Registered fan outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_duty <= 8'h00;
			pwm_valid <= 1'b0;
			active_entry <= 2'b00;
		end else begin
			pwm_duty <= duty_d;
			pwm_valid <= exc5 | exc6;
			active_entry <= sel_d;
		end
	end

	// Read mux; reads show the mode-masked view
	always_comb begin
		unique case (idx)
			10'(`FLUT_IDX_LIMIT5): rd_d = limit_view(limit5_q, temp_hi);
			10'(`FLUT_IDX_DUTY5): rd_d = duty_view(duty5_q, duty_hi);
			10'(`FLUT_IDX_LIMIT6): rd_d = limit_view(limit6_q, temp_hi);
			10'(`FLUT_IDX_DUTY6): rd_d = duty_view(duty6_q, duty_hi);
			10'(`FLUT_IDX_CTRL): rd_d = ctrl_q;
			10'(`FLUT_IDX_STATUS): rd_d = {5'h00, pwm_valid, active_entry};
			10'(`FLUT_IDX_OFFSET): rd_d = offset_q;
			10'(`FLUT_IDX_TEMP): rd_d = temp_q[8:1];
			default: rd_d = 8'h00;
		endcase
	end

	// Read data captured in setup so it stands through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (rd_en)
			prdata <= {24'h00_0000, rd_d};
	end

	// Zero wait states, never an error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
		end
	end

	// Locked write must leave limit 5 unchanged
	property p_lock;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && !ctrl_q[`FLUT_CTRL_UNLOCK]
			&& idx == 10'(`FLUT_IDX_LIMIT5))
		|=> $stable(limit5_q);
	endproperty
	a_lock: assert property (p_lock) else $error("locked write landed");

	property p_unlock;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && ctrl_q[`FLUT_CTRL_UNLOCK]
			&& idx == 10'(`FLUT_IDX_DUTY6))
		|=> {24'h00_0000, duty6_q} == ($past(pwdata) & 32'h0000_00ff);
	endproperty
	a_unlock: assert property (p_unlock) else $error("write lost");

	property p_duty_low;
		@(posedge pclk) disable iff (!presetn)
		(!duty_hi && (exc5 || exc6)) |=> pwm_duty[7:6] == 2'b00;
	endproperty
	a_duty_low: assert property (p_duty_low) else $error("ext bits");

	property p_ext_f;
		@(posedge pclk) disable iff (!presetn)
		(!ctrl_q[`FLUT_CTRL_F22K5] && (exc5 || exc6))
			|=> pwm_duty[7:6] == 2'b00;
	endproperty
	a_ext_f: assert property (p_ext_f) else $error("ext w/o 22k5");

	property p_e6;
		@(posedge pclk) disable iff (!presetn)
		exc6 |=> pwm_duty == ($past(duty_hi) ? $past(duty6_q)
			: ($past(duty6_q) & 8'h3f));
	endproperty
	a_e6: assert property (p_e6) else $error("entry6 duty wrong");

	property p_e5;
		@(posedge pclk) disable iff (!presetn)
		(exc5 && !exc6) |=> active_entry == 2'b01 && pwm_valid;
	endproperty
	a_e5: assert property (p_e5) else $error("entry5 not chosen");

	property p_low_cmp;
		@(posedge pclk) disable iff (!presetn)
		(!temp_hi && offset_q == 8'h00
			&& temp_q[8:1] > {1'b0, limit5_q[6:0]}) |-> exc5;
	endproperty
	a_low_cmp: assert property (p_low_cmp) else $error("cmp low");

	property p_hi_cmp;
		@(posedge pclk) disable iff (!presetn)
		(temp_hi && offset_q == 8'h00
			&& temp_q <= {limit6_q[6:0], limit6_q[7]}) |-> !exc6;
	endproperty
	a_hi_cmp: assert property (p_hi_cmp) else $error("cmp high");

	property p_rdy;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable) |=> pready ##1 !pready;
	endproperty
	a_rdy: assert property (p_rdy) else $error("pready timing");

	// Sync stages disagree: the held reading must not move
	property p_sync_hold;
		@(posedge pclk) disable iff (!presetn)
		(temp_s2_q != temp_s3_q) |=> $stable(temp_q);
	endproperty
	a_sync_hold: assert property (p_sync_hold) else $error("sync");

	// Both limits passed: entry 6 takes the fan
	property p_e6_win;
		@(posedge pclk) disable iff (!presetn)
		(exc5 && exc6) |=> active_entry == 2'b10 && pwm_valid;
	endproperty
	a_e6_win: assert property (p_e6_win) else $error("e6 win");

	// No limit passed: fan outputs idle
	property p_none;
		@(posedge pclk) disable iff (!presetn)
		!(exc5 || exc6) |=> !pwm_valid && pwm_duty == 8'h00
			&& active_entry == 2'b00;
	endproperty
	a_none: assert property (p_none) else $error("idle");

	// Low-res read of a limit never shows bit 7
	property p_lrd_low;
		@(posedge pclk) disable iff (!presetn)
		(rd_en && !temp_hi && idx == 10'(`FLUT_IDX_LIMIT5))
			|=> prdata[7] == 1'b0;
	endproperty
	a_lrd_low: assert property (p_lrd_low) else $error("bit7");

	// Low-res duty read keeps bits 7:6 clear
	property p_drd_low;
		@(posedge pclk) disable iff (!presetn)
		(rd_en && !duty_hi && idx == 10'(`FLUT_IDX_DUTY5))
			|=> prdata[7:6] == 2'b00;
	endproperty
	a_drd_low: assert property (p_drd_low) else $error("7:6");

	// Locked write must leave duty 6 unchanged
	property p_lock6;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && !ctrl_q[`FLUT_CTRL_UNLOCK]
			&& idx == 10'(`FLUT_IDX_DUTY6))
		|=> $stable(duty6_q);
	endproperty
	a_lock6: assert property (p_lock6) else $error("locked d6");

	// Offset only raises a limit, never lowers it
	property p_off;
		@(posedge pclk) disable iff (!presetn)
		(temp_hi && temp_q <= {limit5_q[6:0], limit5_q[7]})
			|-> !exc5;
	endproperty
	a_off: assert property (p_off) else $error("offset");

	// Low-res duty: entry 5 output is its bits 5:0
	property p_e5_low;
		@(posedge pclk) disable iff (!presetn)
		(exc5 && !exc6 && !duty_hi)
			|=> pwm_duty == ($past(duty5_q) & 8'h3f);
	endproperty
	a_e5_low: assert property (p_e5_low) else $error("e5 low");

	// High-res duty: entry 5 output is the whole byte
	property p_e5_hi;
		@(posedge pclk) disable iff (!presetn)
		(exc5 && !exc6 && duty_hi) |=> pwm_duty == $past(duty5_q);
	endproperty
	a_e5_hi: assert property (p_e5_hi) else $error("e5 high");

	// High-res read of a limit shows all eight stored bits
	property p_hi_rd;
		@(posedge pclk) disable iff (!presetn)
		(rd_en && temp_hi && idx == 10'(`FLUT_IDX_LIMIT5))
			|=> prdata[7:0] == $past(limit5_q);
	endproperty
	a_hi_rd: assert property (p_hi_rd) else $error("hi read");
endmodule : flut_entries

// ### flut_host.sv
// Purpose: APB host model driving the fan table entries
// Assumes: Slave raises pready during the access phase
// Notes:   Wait is open ended; the bench watchdog ends a hang
`timescale 1ns/1ps
module flut_host (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready
);
	// Idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
	end

	// Setup, then access held until pready is seen high
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : flut_host

// ### flut_entries_tb.sv
// Purpose: Self-checking bench for fan table entries 5 and 6
// Assumes: Fan outputs settle within six edges of a reading change
// Notes:   Only non-negative limits are programmed
`timescale 1ns/1ps
`include "flut_regs.svh"
module flut_entries_tb;
	import flut_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite;
	logic        pready, pslverr, pwm_valid;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [8:0]  remote_temp;
	logic [7:0]  pwm_duty;
	logic [1:0]  active_entry;
	int          fail_count, tests_run;

	flut_entries u_flut_entries (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .remote_temp(remote_temp),
		.pwm_valid(pwm_valid), .pwm_duty(pwm_duty),
		.active_entry(active_entry));
	flut_host u_host (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready));

	// 200 MHz clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// Byte address is four times the index
	function automatic logic [11:0] ba(input logic [7:0] i);
		return {2'b00, i, 2'b00};
	endfunction : ba

	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic wr(logic [7:0] i, logic [7:0] d);
		logic [31:0] r;
		u_host.xfer(1'b1, ba(i), {24'h0, d}, r);
	endtask : wr

	task automatic rd(logic [11:0] a, logic [7:0] e);
		logic [31:0] r;
		u_host.xfer(1'b0, a, 32'h0, r);
		chk("prdata", {24'h0, e}, r);
		chk("pslverr", 0, pslverr);
	endtask : rd

	// Reading change, then the fixed sync and compare latency
	task automatic fan(logic [8:0] t, logic v, logic [7:0] d,
		logic [1:0] en);
		@(posedge pclk);
		remote_temp <= t;
		repeat (6) @(posedge pclk);
		chk("pwm_valid", v, pwm_valid);
		chk("pwm_duty", d, pwm_duty);
		chk("active_entry", en, active_entry);
	endtask : fan

	task automatic t_reset;
		rd(ba(`FLUT_IDX_LIMIT5), 8'h7f);
		rd(ba(`FLUT_IDX_DUTY5), 8'h3f);
		rd(ba(`FLUT_IDX_LIMIT6), 8'h7f);
		rd(ba(`FLUT_IDX_DUTY6), 8'h3f);
		rd(12'h000, 8'h00);
		fan(9'h000, 1'b0, 8'h00, 2'b00);
		wr(`FLUT_IDX_LIMIT5, 8'h10);
		rd(ba(`FLUT_IDX_LIMIT5), 8'h7f);
	endtask : t_reset

	// Low resolution: bit 7 of limits, bits 7:6 of duties masked
	task automatic t_lowres;
		wr(`FLUT_IDX_CTRL, 8'h20);
		wr(`FLUT_IDX_LIMIT5, 8'h85);
		wr(`FLUT_IDX_DUTY5, 8'hc5);
		wr(`FLUT_IDX_LIMIT6, 8'h94);
		wr(`FLUT_IDX_DUTY6, 8'hea);
		rd(ba(`FLUT_IDX_LIMIT5), 8'h05);
		rd(ba(`FLUT_IDX_DUTY5), 8'h05);
		fan(9'd12, 1'b1, 8'h05, 2'b01);
		fan(9'd11, 1'b0, 8'h00, 2'b00);
		fan(9'd42, 1'b1, 8'h2a, 2'b10);
	endtask : t_lowres

	task automatic t_hires;
		wr(`FLUT_IDX_CTRL, 8'h23);
		rd(ba(`FLUT_IDX_DUTY5), 8'h05);
		fan(9'd12, 1'b1, 8'h05, 2'b01);
		wr(`FLUT_IDX_CTRL, 8'h27);
		rd(ba(`FLUT_IDX_LIMIT5), 8'h85);
		rd(ba(`FLUT_IDX_DUTY5), 8'hc5);
		fan(9'd11, 1'b0, 8'h00, 2'b00);
		fan(9'd42, 1'b1, 8'hea, 2'b10);
		fan(9'd41, 1'b1, 8'hc5, 2'b01);
		// Offset of ten degrees lifts limit 5 to 15.5
		wr(`FLUT_IDX_OFFSET, 8'h0a);
		fan(9'd31, 1'b0, 8'h00, 2'b00);
		fan(9'd32, 1'b1, 8'hc5, 2'b01);
		rd(ba(`FLUT_IDX_STATUS), 8'h05);
		rd(ba(`FLUT_IDX_TEMP), 8'h10);
		rd(ba(`FLUT_IDX_OFFSET), 8'h0a);
		// Relock, then a write to entry 6 must not land
		wr(`FLUT_IDX_CTRL, 8'h07);
		wr(`FLUT_IDX_DUTY6, 8'h11);
		rd(ba(`FLUT_IDX_DUTY6), 8'hea);
		rd(ba(`FLUT_IDX_CTRL), 8'h07);
	endtask : t_hires

	task automatic results;
		$display("Counts: tests_run=%0d fail_count=%0d", tests_run,
			fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results

	// Watchdog well past the expected run
	initial begin
		repeat (5000) @(posedge pclk);
		fail_count++;
		results();
	end

	initial begin
		fail_count = 0;
		tests_run = 0;
		presetn = 1'b0;
		remote_temp = 9'h000;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_lowres();
		t_hires();
		results();
	end
endmodule : flut_entries_tb
